// [src/cmt_message_timer.sv]
`timescale 1ns/1ps
module cmt_message_timer
  import cmt_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       SFR_RD,
  input  wire logic       SFR_WR,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       STAMP_EVENT,
  input  wire logic       TTC_EVENT,
  output logic      [7:0] SFR_RDATA,
  output logic      [15:0] TIMER_VALUE
);

  logic         rst_meta_reg;
  logic         rst_sync_reg;
  logic         rst_n;
  cmt_sfr_req_s req;

  logic [7:0]  prescale_value_reg;
  logic [7:0]  prescale_value_next;
  logic [15:0] message_timer_count_reg;
  logic [15:0] message_timer_count_next;
  logic [15:0] stamp_capture_value_reg;
  logic [15:0] stamp_capture_value_next;
  logic [15:0] ttc_capture_value_reg;
  logic [15:0] ttc_capture_value_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        tick;

  // Reset enters asynchronously, released through two flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  assign req = '{rd: SFR_RD, wr: SFR_WR, addr: SFR_ADDR, wdata: SFR_WDATA};

  cmt_prescaler u_prescaler (
    .clk          (CLK),
    .rst_n        (rst_n),
    .divide_value (prescale_value_reg),
    .tick         (tick)
  );

  always_comb begin
    prescale_value_next      = prescale_value_reg;
    message_timer_count_next = message_timer_count_reg;
    stamp_capture_value_next = stamp_capture_value_reg;
    ttc_capture_value_next   = ttc_capture_value_reg;
    if (req.wr && req.addr == CMT_ADDR_PRESCALE) begin
      prescale_value_next = req.wdata;
    end
    if (tick) begin
      message_timer_count_next = message_timer_count_reg + 16'h0001;
    end
    // Software write to a timer byte overrides that byte only; the other byte keeps the count step
    if (req.wr && req.addr == CMT_ADDR_TIMER_LOW) begin
      message_timer_count_next[7:0] = req.wdata;
    end
    if (req.wr && req.addr == CMT_ADDR_TIMER_HIGH) begin
      message_timer_count_next[15:8] = req.wdata;
    end
    // Captures load only from frame events; bus writes are ignored
    if (STAMP_EVENT) begin
      stamp_capture_value_next = message_timer_count_reg;
    end
    if (TTC_EVENT) begin
      ttc_capture_value_next = message_timer_count_reg;
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (req.rd) begin
      case (req.addr)
        CMT_ADDR_PRESCALE:   rdata_next = prescale_value_reg;
        CMT_ADDR_TIMER_LOW:  rdata_next = message_timer_count_reg[7:0];
        CMT_ADDR_TIMER_HIGH: rdata_next = message_timer_count_reg[15:8];
        CMT_ADDR_STAMP_LOW:  rdata_next = stamp_capture_value_reg[7:0];
        CMT_ADDR_STAMP_HIGH: rdata_next = stamp_capture_value_reg[15:8];
        CMT_ADDR_TTC_LOW:    rdata_next = ttc_capture_value_reg[7:0];
        CMT_ADDR_TTC_HIGH:   rdata_next = ttc_capture_value_reg[15:8];
        default:             rdata_next = CMT_READ_UNMAPPED;
      endcase
    end
  end

  // Captures are reset to zero too, harmless where undefined is allowed
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prescale_value_reg      <= CMT_PRESCALE_RESET;
      message_timer_count_reg <= CMT_TIMER_RESET;
      stamp_capture_value_reg <= CMT_CAPTURE_RESET;
      ttc_capture_value_reg   <= CMT_CAPTURE_RESET;
      rdata_reg               <= CMT_READ_UNMAPPED;
    end else begin
      prescale_value_reg      <= prescale_value_next;
      message_timer_count_reg <= message_timer_count_next;
      stamp_capture_value_reg <= stamp_capture_value_next;
      ttc_capture_value_reg   <= ttc_capture_value_next;
      rdata_reg               <= rdata_next;
    end
  end

  assign SFR_RDATA   = rdata_reg;
  assign TIMER_VALUE = message_timer_count_reg;

  // Assertions
  // Edges since the timer last moved; a write may restart the period
  logic [8:0] gap_cnt_reg;
  logic [8:0] gap_cnt_next;

  always_comb begin
    if (req.wr || message_timer_count_next != message_timer_count_reg) begin
      gap_cnt_next = 9'h000;
    end else begin
      gap_cnt_next = gap_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_reg <= 9'h000;
    end else begin
      gap_cnt_reg <= gap_cnt_next;
    end
  end

  sequence s_quiet_bus;
    !req.wr;
  endsequence

  property p_divide;
    @(posedge CLK) disable iff (!rst_n)
      (s_quiet_bus [*2]) |-> gap_cnt_reg <= {1'b0, prescale_value_reg};
  endproperty
  a_divide: assert property (p_divide) else $error("timer stalled past prescale period");

  property p_step;
    @(posedge CLK) disable iff (!rst_n)
      (tick && !req.wr) |=> message_timer_count_reg == $past(message_timer_count_reg) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("timer did not step by one");

  property p_hold;
    @(posedge CLK) disable iff (!rst_n)
      (!tick && !req.wr) |=> $stable(message_timer_count_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("timer moved without a tick");

  property p_undivided;
    @(posedge CLK) disable iff (!rst_n)
      (prescale_value_reg == 8'h00) |-> tick;
  endproperty
  a_undivided: assert property (p_undivided) else $error("zero prescale not undivided");

  property p_read_high;
    @(posedge CLK) disable iff (!rst_n)
      (req.rd && req.addr == CMT_ADDR_TIMER_HIGH) |=> SFR_RDATA == $past(message_timer_count_reg[15:8]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high byte read wrong");

  property p_read_low;
    @(posedge CLK) disable iff (!rst_n)
      (req.rd && req.addr == CMT_ADDR_TIMER_LOW) |=> SFR_RDATA == $past(message_timer_count_reg[7:0]);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low byte read wrong");

  property p_stamp_ro;
    @(posedge CLK) disable iff (!rst_n)
      (!STAMP_EVENT) |=> $stable(stamp_capture_value_reg);
  endproperty
  a_stamp_ro: assert property (p_stamp_ro) else $error("stamp changed without event");

  property p_stamp_low;
    @(posedge CLK) disable iff (!rst_n)
      STAMP_EVENT |=> stamp_capture_value_reg[7:0] == $past(message_timer_count_reg[7:0]);
  endproperty
  a_stamp_low: assert property (p_stamp_low) else $error("stamp low byte not captured");

  property p_ttc;
    @(posedge CLK) disable iff (!rst_n)
      (!TTC_EVENT) |=> $stable(ttc_capture_value_reg);
  endproperty
  a_ttc: assert property (p_ttc) else $error("ttc capture changed without event");

  property p_ttc_load;
    @(posedge CLK) disable iff (!rst_n)
      TTC_EVENT |=> ttc_capture_value_reg == $past(message_timer_count_reg);
  endproperty
  a_ttc_load: assert property (p_ttc_load) else $error("ttc capture not loaded");

  property p_stamp_high;
    @(posedge CLK) disable iff (!rst_n)
      STAMP_EVENT |=> stamp_capture_value_reg[15:8] == $past(message_timer_count_reg[15:8]);
  endproperty
  a_stamp_high: assert property (p_stamp_high) else $error("stamp high byte not captured");

  sequence s_prescale_write;
    req.wr && req.addr == CMT_ADDR_PRESCALE;
  endsequence

  property p_prescale_load;
    @(posedge CLK) disable iff (!rst_n)
      s_prescale_write |=> prescale_value_reg == $past(req.wdata);
  endproperty
  a_prescale_load: assert property (p_prescale_load) else $error("prescale write lost");

  property p_wrap;
    @(posedge CLK) disable iff (!rst_n)
      (tick && !req.wr && message_timer_count_reg == 16'hffff) |=> message_timer_count_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer did not wrap to zero");

endmodule : cmt_message_timer

// [src/cmt_pkg.sv]
package cmt_pkg;

  // Special function register addresses
  localparam logic [7:0] CMT_ADDR_PRESCALE   = 8'ha1;
  localparam logic [7:0] CMT_ADDR_TTC_LOW    = 8'ha4;
  localparam logic [7:0] CMT_ADDR_TTC_HIGH   = 8'ha5;
  localparam logic [7:0] CMT_ADDR_TIMER_LOW  = 8'hac;
  localparam logic [7:0] CMT_ADDR_TIMER_HIGH = 8'had;
  localparam logic [7:0] CMT_ADDR_STAMP_LOW  = 8'hae;
  localparam logic [7:0] CMT_ADDR_STAMP_HIGH = 8'haf;

  localparam logic [7:0]  CMT_PRESCALE_RESET = 8'h00;
  localparam logic [15:0] CMT_TIMER_RESET    = 16'h0000;
  localparam logic [15:0] CMT_CAPTURE_RESET  = 16'h0000;
  localparam logic [7:0]  CMT_READ_UNMAPPED  = 8'h00;
  localparam logic [7:0]  CMT_DIVIDER_RESET  = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmt_sfr_req_s;

endpackage : cmt_pkg

// [src/cmt_prescaler.sv]
`timescale 1ns/1ps
module cmt_prescaler
  import cmt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] divide_value,
  output logic            tick
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       tick_next;

  // Tick once every divide_value+1 clocks
  always_comb begin
    if (count_reg >= divide_value) begin
      count_next = 8'h00;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 8'h01;
      tick_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= CMT_DIVIDER_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  assign tick = tick_next;

endmodule : cmt_prescaler

// [tb/can_message_timer_bench.sv]
`timescale 1ns/1ps
module can_message_timer_bench
  import cmt_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0, sfr_rd = 1'b0, sfr_wr = 1'b0, stamp_event = 1'b0, ttc_event = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
  logic [15:0] timer_value, v;
  int          miscompares = 0, compares = 0, n;

  always #5 clk = ~clk;

  cmt_message_timer uut (.CLK(clk), .RESET_N(reset_n), .SFR_RD(sfr_rd), .SFR_WR(sfr_wr), .SFR_ADDR(sfr_addr),
    .SFR_WDATA(sfr_wdata), .STAMP_EVENT(stamp_event), .TTC_EVENT(ttc_event), .SFR_RDATA(sfr_rdata),
    .TIMER_VALUE(timer_value));

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_rd <= 1'b1; sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask : sfr_read

  // Counts clocks until the timer moves; a stuck timer ends the run
  task automatic wait_step(output int cnt);
    logic [15:0] old;
    #1 old = timer_value;
    for (cnt = 1; cnt <= 600; cnt++) begin
      @(posedge clk);
      #1 if (timer_value !== old) return;
    end
    miscompares++;
    wrap_up();
  endtask : wait_step

  task automatic t_reset;
    sfr_read(CMT_ADDR_PRESCALE, rd); chk("prescale", 16'h0000, {8'h00, rd});
    sfr_read(CMT_ADDR_TIMER_HIGH, rd); chk("timer high", 16'h0000, {8'h00, rd});
    wait_step(n); wait_step(n); chk("period", 16'h0001, 16'(n));
  endtask : t_reset

  task automatic t_prescale;
    sfr_write(CMT_ADDR_PRESCALE, 8'h03);
    wait_step(n); wait_step(n); chk("period", 16'h0004, 16'(n));
    sfr_write(CMT_ADDR_PRESCALE, 8'hff);
    wait_step(n); wait_step(n); chk("period", 16'h0100, 16'(n));
    sfr_read(CMT_ADDR_PRESCALE, rd); chk("prescale", 16'h00ff, {8'h00, rd});
  endtask : t_prescale

  task automatic t_timer;
    wait_step(n);
    sfr_write(CMT_ADDR_TIMER_LOW, 8'hff);
    sfr_write(CMT_ADDR_TIMER_HIGH, 8'hff);
    sfr_read(CMT_ADDR_TIMER_LOW, rd); chk("timer low", 16'h00ff, {8'h00, rd});
    sfr_read(CMT_ADDR_TIMER_HIGH, rd); chk("timer high", 16'h00ff, {8'h00, rd});
    chk("timer", 16'hffff, timer_value);
    wait_step(n); chk("wrap", 16'h0000, timer_value);
  endtask : t_timer

  task automatic t_capture;
    wait_step(n); wait_step(n);
    v = 16'h0002;
    chk("timer", v, timer_value);
    @(posedge clk) stamp_event <= 1'b1;
    @(posedge clk) stamp_event <= 1'b0;
    sfr_write(CMT_ADDR_STAMP_HIGH, ~v[15:8]);
    sfr_write(CMT_ADDR_STAMP_LOW, ~v[7:0]);
    sfr_read(CMT_ADDR_STAMP_HIGH, rd); chk("stamp high", {8'h00, v[15:8]}, {8'h00, rd});
    sfr_read(CMT_ADDR_STAMP_LOW, rd); chk("stamp low", {8'h00, v[7:0]}, {8'h00, rd});
    wait_step(n);
    @(posedge clk) ttc_event <= 1'b1;
    @(posedge clk) ttc_event <= 1'b0;
    sfr_write(CMT_ADDR_TTC_LOW, 8'h5a);
    sfr_write(CMT_ADDR_TTC_HIGH, 8'hff);
    sfr_read(CMT_ADDR_TTC_HIGH, rd); chk("ttc high", 16'h0000, {8'h00, rd});
    sfr_read(CMT_ADDR_TTC_LOW, rd); chk("ttc low", 16'h0003, {8'h00, rd});
    sfr_read(CMT_ADDR_STAMP_LOW, rd); chk("stamp kept", {8'h00, v[7:0]}, {8'h00, rd});
    sfr_read(8'ha2, rd); chk("unmapped", {8'h00, CMT_READ_UNMAPPED}, {8'h00, rd});
  endtask : t_capture

  // Mid-run reset must bring back the undivided rate and a zero high byte
  task automatic t_rereset;
    sfr_write(CMT_ADDR_TIMER_HIGH, 8'h5a);
    sfr_read(CMT_ADDR_TIMER_HIGH, rd); chk("timer high", 16'h005a, {8'h00, rd});
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("timer in reset", 16'h0000, timer_value);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
  endtask : t_rereset

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_prescale();
    t_timer();
    t_capture();
    t_rereset();
    wrap_up();
  end
endmodule : can_message_timer_bench
